/* File: rtl/mipsm_top.v */
// Module-wide init and power state machine with register port
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "mipsm_map.vh"
module mipsm_top #(
  parameter NUM_LG       = 8,
  parameter HW_INIT_SUPP = 1,
  parameter RST_MIN_NS   = 10000,
  parameter INIT_MAX_CYC = 40000,
  parameter LG_INIT_CYC  = 16,
  parameter [7:0] HW_PWRUP_DEFAULT = 8'hFF
) (
  // Clock, reset, enable
  input  wire                    clk_i,
  input  wire                    nrst_i,
  input  wire                    ce_i,
  // Module pins
  input  wire                    reset_pin_n_i,
  input  wire                    low_power_request_pin_i,
  input  wire                    init_mode_hw_i,
  input  wire                    power_good_i,
  input  wire                    fault_i,
  // Register port
  input  wire [`MIPSM_ADDR_W-1:0] addr_i,
  input  wire [7:0]              wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  output wire [7:0]              rdata_o,
  // Status
  output wire [`MIPSM_ST_W-1:0]  module_state_o,
  output wire                    high_power_o,
  output wire                    electronics_rst_o,
  output wire                    mgmt_ready_o,
  output wire                    init_timeout_o,
  output wire                    state_changed_o,
  output wire [2*NUM_LG-1:0]     lane_state_o
);
  ////////////////////////////////////////////////////////////////////////
  localparam RST_MIN_CYC = (RST_MIN_NS + `MIPSM_CLK_NS - 1) / `MIPSM_CLK_NS;
  // Reload kept apart so it is cut to the counter width on purpose
  localparam SWR_CYC     = `MIPSM_SW_RST_CYC;
  localparam ST_RESET     = `MIPSM_ST_RESET;
  localparam ST_MGMT_INIT = `MIPSM_ST_MGMT_INIT;
  localparam ST_LOW_PWR   = `MIPSM_ST_LOW_PWR;
  localparam ST_PWR_UP    = `MIPSM_ST_PWR_UP;
  localparam ST_READY     = `MIPSM_ST_READY;
  localparam ST_PWR_DN    = `MIPSM_ST_PWR_DN;
  localparam ST_FAULT     = `MIPSM_ST_FAULT;

  function all_state;
    input [2*NUM_LG-1:0] v;
    input [1:0]          code;
    input [NUM_LG-1:0]   sel;
    integer k;
    begin
      all_state = 1'b1;
      for (k = 0; k < NUM_LG; k = k + 1) begin
        if (sel[k] && (v[2*k +: 2] != code)) begin
          all_state = 1'b0;
        end
      end
    end
  endfunction

  // Lane bits widened to the byte read port; upper bits read as zero
  function [7:0] pad_byte;
    input [NUM_LG-1:0] v;
    integer k;
    begin
      pad_byte = 8'h00;
      for (k = 0; (k < NUM_LG) && (k < 8); k = k + 1) begin
        pad_byte[k] = v[k];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  wire rst_pin_n_s;
  wire lp_pin_s;
  wire init_mode_s;
  wire pgood_s;
  wire fault_s;

  mipsm_sync3 #(.RESET_VAL(1'b1)) u_sync_rst (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .async_i(~reset_pin_n_i), .sync_o(rst_pin_n_s)
  );
  mipsm_sync3 #(.RESET_VAL(1'b0)) u_sync_lp (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .async_i(low_power_request_pin_i), .sync_o(lp_pin_s)
  );
  mipsm_sync3 #(.RESET_VAL(1'b0)) u_sync_im (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .async_i(init_mode_hw_i), .sync_o(init_mode_s)
  );
  mipsm_sync3 #(.RESET_VAL(1'b0)) u_sync_pg (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .async_i(power_good_i), .sync_o(pgood_s)
  );
  mipsm_sync3 #(.RESET_VAL(1'b0)) u_sync_flt (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .async_i(fault_i), .sync_o(fault_s)
  );

  ////////////////////////////////////////////////////////////////////////
  reg [`MIPSM_ST_W-1:0] st_q;
  reg [`MIPSM_ST_W-1:0] st_d;
  reg [15:0]            rst_cnt_q;
  reg                   hw_rst_q;
  reg [3:0]             swr_cnt_q;
  reg [31:0]            init_cnt_q;
  reg                   hw_mode_q;
  reg                   force_lp_q;
  reg [NUM_LG-1:0]      pwrup_q;
  reg                   chg_flag_q;
  reg                   timeout_q;
  reg [7:0]             rdata_q;
  wire [2*NUM_LG-1:0]   lane_st;

  wire lp_req   = force_lp_q | lp_pin_s;
  wire in_reset = (st_q == ST_RESET);
  wire in_init  = (st_q == ST_MGMT_INIT);
  wire init_done = in_init &&
                   ((init_cnt_q >= `MIPSM_INIT_WORK_CYC) || (init_cnt_q >= INIT_MAX_CYC - 1));
  wire lanes_all_off = all_state(lane_st, `MIPSM_LG_INACTIVE, {NUM_LG{1'b1}});
  wire lanes_req_on  = all_state(lane_st, `MIPSM_LG_ACTIVE, pwrup_q);
  wire swr_pulse = wr_i && (addr_i == `MIPSM_REG_CTRL) && wdata_i[`MIPSM_CTRL_SW_RESET] &&
                   !in_reset && !in_init;

  // Pin reset qualified by minimum pulse length
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_cnt_q <= 16'h0000;
      hw_rst_q  <= 1'b1;
    end else if (ce_i) begin
      if (rst_pin_n_s) begin
        rst_cnt_q <= 16'h0000;
        hw_rst_q  <= 1'b0;
      end else if (rst_cnt_q >= RST_MIN_CYC[15:0] - 16'h0001) begin
        hw_rst_q <= 1'b1;
      end else begin
        rst_cnt_q <= rst_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_RESET: begin
        if (!hw_rst_q && rst_pin_n_s && pgood_s && (swr_cnt_q == 4'h0)) begin
          st_d = ST_MGMT_INIT;
        end
      end
      ST_MGMT_INIT: begin
        if (fault_s) begin
          st_d = ST_FAULT;
        end else if (init_done) begin
          st_d = hw_mode_q ? ST_PWR_UP : ST_LOW_PWR;
        end
      end
      ST_LOW_PWR: begin
        if (fault_s) begin
          st_d = ST_FAULT;
        end else if (!lp_req && (|pwrup_q)) begin
          st_d = ST_PWR_UP;
        end
      end
      ST_PWR_UP: begin
        if (fault_s) begin
          st_d = ST_FAULT;
        end else if (lp_req) begin
          st_d = ST_PWR_DN;
        end else if (lanes_req_on) begin
          st_d = ST_READY;
        end
      end
      ST_READY: begin
        if (fault_s) begin
          st_d = ST_FAULT;
        end else if (lp_req) begin
          st_d = ST_PWR_DN;
        end
      end
      ST_PWR_DN: begin
        if (fault_s) begin
          st_d = ST_FAULT;
        end else if (lanes_all_off) begin
          st_d = ST_LOW_PWR;
        end
      end
      ST_FAULT: begin
        st_d = ST_FAULT;
      end
      default: begin
        st_d = ST_RESET;
      end
    endcase
    if (hw_rst_q || swr_pulse) begin
      st_d = ST_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q       <= ST_RESET;
      swr_cnt_q  <= 4'h0;
      init_cnt_q <= 32'h00000000;
      hw_mode_q  <= 1'b0;
      force_lp_q <= 1'b0;
      pwrup_q    <= {NUM_LG{1'b0}};
      chg_flag_q <= 1'b0;
      timeout_q  <= 1'b0;
      rdata_q    <= 8'h00;
    end else if (ce_i) begin
      st_q    <= st_d;
      rdata_q <= 8'h00;
      // Software reset stays transient
      if (swr_pulse) begin
        swr_cnt_q <= SWR_CYC[3:0];
      end else if (swr_cnt_q != 4'h0) begin
        swr_cnt_q <= swr_cnt_q - 4'h1;
      end
      if (in_init) begin
        init_cnt_q <= init_cnt_q + 32'h00000001;
        if (init_cnt_q >= INIT_MAX_CYC - 1) begin
          timeout_q <= 1'b1;
        end
        // Init mode only looked at here; held until next reset
        if (HW_INIT_SUPP != 0) begin
          hw_mode_q <= init_mode_s && !lp_req;
        end else begin
          hw_mode_q <= 1'b0;
        end
        // Register defaults loaded during init
        force_lp_q <= 1'b0;
        pwrup_q    <= (HW_INIT_SUPP != 0 && init_mode_s && !lp_req) ?
                      HW_PWRUP_DEFAULT[NUM_LG-1:0] : {NUM_LG{1'b0}};
        chg_flag_q <= 1'b0;
      end else begin
        init_cnt_q <= 32'h00000000;
      end
      if (in_reset) begin
        timeout_q  <= 1'b0;
        chg_flag_q <= 1'b0;
      end
      // Register writes refused while in reset or init
      if (wr_i && !in_reset && !in_init) begin
        if (addr_i == `MIPSM_REG_CTRL) begin
          force_lp_q <= wdata_i[`MIPSM_CTRL_FORCE_LP];
        end
        if (addr_i == `MIPSM_REG_PWRUP) begin
          pwrup_q <= wdata_i[NUM_LG-1:0];
        end
      end
      // Read to clear; a new event on the same cycle wins
      if (rd_i && !in_reset && !in_init && addr_i == `MIPSM_REG_FLAGS) begin
        chg_flag_q <= 1'b0;
      end
      if ((st_q != st_d) && !hw_rst_q && !swr_pulse &&
          (st_d == ST_FAULT ||
           (st_q == ST_MGMT_INIT && st_d == ST_LOW_PWR) ||
           (st_q == ST_PWR_UP && st_d == ST_READY) ||
           (st_q == ST_PWR_DN && st_d == ST_LOW_PWR))) begin
        chg_flag_q <= 1'b1;
      end
      if (rd_i && !in_reset && !in_init) begin
        case (addr_i)
          `MIPSM_REG_CTRL:       rdata_q <= {7'h00, force_lp_q};
          `MIPSM_REG_PWRUP:      rdata_q <= pad_byte(pwrup_q);
          `MIPSM_REG_STATE:      rdata_q <= {1'b0, st_q};
          `MIPSM_REG_FLAGS:      rdata_q <= {7'h00, chg_flag_q};
          `MIPSM_REG_LANE_STATE: rdata_q <= {6'h00, lane_st[1:0]};
          default:               rdata_q <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < NUM_LG; g = g + 1) begin : g_lane
      mipsm_lane_fsm #(.INIT_CYC(LG_INIT_CYC)) u_lane (
        .clk_i            (clk_i),
        .nrst_i           (nrst_i),
        .ce_i             (ce_i),
        .force_inactive_i (in_reset || in_init || st_q == ST_FAULT),
        .force_deinit_i   (st_q == ST_PWR_DN),
        .allow_up_i       (st_q == ST_PWR_UP || st_q == ST_READY),
        .power_req_i      (pwrup_q[g]),
        .state_o          (lane_st[2*g +: 2])
      );
    end
  endgenerate

  // High power only in powering up, ready and powering down
  assign high_power_o      = (st_q == ST_PWR_UP) || (st_q == ST_READY) || (st_q == ST_PWR_DN);
  assign electronics_rst_o = in_reset;
  assign mgmt_ready_o      = !in_reset && !in_init;
  assign init_timeout_o    = timeout_q;
  assign state_changed_o   = chg_flag_q;
  assign module_state_o    = st_q;
  assign lane_state_o      = lane_st;
  assign rdata_o           = rdata_q;
endmodule // mipsm_top

/* File: rtl/mipsm_map.vh */
// Register offsets, fields, state codes and timing for the module state machine
`ifndef MIPSM_MAP_VH
`define MIPSM_MAP_VH

// Register offsets
`define MIPSM_ADDR_W          4
`define MIPSM_REG_CTRL        4'h0
`define MIPSM_REG_PWRUP       4'h1
`define MIPSM_REG_STATE       4'h2
`define MIPSM_REG_FLAGS       4'h3
`define MIPSM_REG_LANE_STATE  4'h4

// Control register fields
`define MIPSM_CTRL_FORCE_LP   0
`define MIPSM_CTRL_SW_RESET   1

// Flag register fields
`define MIPSM_FLAG_STATE_CHG  0

// Module state codes (one-hot)
`define MIPSM_ST_W            7
`define MIPSM_ST_RESET        7'h01
`define MIPSM_ST_MGMT_INIT    7'h02
`define MIPSM_ST_LOW_PWR      7'h04
`define MIPSM_ST_PWR_UP       7'h08
`define MIPSM_ST_READY        7'h10
`define MIPSM_ST_PWR_DN       7'h20
`define MIPSM_ST_FAULT        7'h40

// Lane group state codes (two bits each)
`define MIPSM_LG_INACTIVE     2'h0
`define MIPSM_LG_INIT         2'h1
`define MIPSM_LG_ACTIVE       2'h2
`define MIPSM_LG_DEINIT       2'h3

// Timing
`define MIPSM_CLK_NS          50
`define MIPSM_INIT_WORK_CYC   8
`define MIPSM_SW_RST_CYC      4

`endif

/* File: rtl/mipsm_sync3.v */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module mipsm_sync3 #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire clk_i,
  input  wire nrst_i,
  input  wire ce_i,
  // Data
  input  wire async_i,
  output wire sync_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg out_q;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      out_q <= 1'b0;
    end else if (ce_i) begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change counts only when the last two stages agree
      if (s2_q == s3_q) begin
        out_q <= s3_q;
      end
    end
  end

  // Reset level applied by inverting polarity around zero constants
  assign sync_o = out_q ^ RESET_VAL;
endmodule // mipsm_sync3

/* File: rtl/mipsm_lane_fsm.v */
// Per lane group state tracker driven by the module state machine
`timescale 1ns/1ns
`include "mipsm_map.vh"
module mipsm_lane_fsm #(
  parameter INIT_CYC = 16
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire       ce_i,
  // Control from module state machine
  input  wire       force_inactive_i,
  input  wire       force_deinit_i,
  input  wire       allow_up_i,
  input  wire       power_req_i,
  // Status
  output wire [1:0] state_o
);
  reg [1:0]  st_q;
  reg [15:0] cnt_q;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q  <= `MIPSM_LG_INACTIVE;
      cnt_q <= 16'h0000;
    end else if (ce_i) begin
      if (force_inactive_i) begin
        st_q  <= `MIPSM_LG_INACTIVE;
        cnt_q <= 16'h0000;
      end else if (force_deinit_i) begin
        if (st_q != `MIPSM_LG_INACTIVE) begin
          st_q <= `MIPSM_LG_DEINIT;
        end
        if (st_q == `MIPSM_LG_DEINIT) begin
          st_q <= `MIPSM_LG_INACTIVE;
        end
      end else begin
        case (st_q)
          `MIPSM_LG_INACTIVE: begin
            if (allow_up_i && power_req_i) begin
              st_q  <= `MIPSM_LG_INIT;
              cnt_q <= 16'h0000;
            end
          end
          `MIPSM_LG_INIT: begin
            if (!power_req_i) begin
              st_q <= `MIPSM_LG_DEINIT;
            end else if (cnt_q == INIT_CYC[15:0] - 16'h0001) begin
              st_q <= `MIPSM_LG_ACTIVE;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
          `MIPSM_LG_ACTIVE: begin
            if (!power_req_i) begin
              st_q <= `MIPSM_LG_DEINIT;
            end
          end
          default: begin
            st_q <= `MIPSM_LG_INACTIVE;
          end
        endcase
      end
    end
  end

  assign state_o = st_q;
endmodule // mipsm_lane_fsm

/* File: sim/mipsm_host_model.sv */
// Host side model driving the module reset pin and supply
`timescale 1ns/1ns
module mipsm_host_model #(
  parameter RST_CYC = 6
) (
  // Clock
  input  wire logic clk_i,
  // Bench requests
  input  wire logic rst_req_i,
  input  wire logic supply_on_i,
  // Pins to module
  output logic      reset_pin_n_o,
  output logic      power_good_o
);
  int rst_cnt_q = 0;
  int pg_cnt_q  = 0;
  ////////////////////////////////////////////////////////////
  // Pulse stretched past the minimum width, never a glitch
  always @(posedge clk_i) begin
    if (rst_req_i) rst_cnt_q <= RST_CYC;
    else if (rst_cnt_q != 0) rst_cnt_q <= rst_cnt_q - 1;
    pg_cnt_q <= supply_on_i ? ((pg_cnt_q < 3) ? pg_cnt_q + 1 : 3) : 0;
  end
  assign reset_pin_n_o = (rst_cnt_q == 0) && !rst_req_i;
  assign power_good_o  = (pg_cnt_q == 3);
endmodule // mipsm_host_model

/* File: sim/mipsm_checker.sv */
// Port assertions for the module state machine
`timescale 1ns/1ns
`include "mipsm_map.vh"
module mipsm_checker #(
  parameter NUM_LG = 8
) (
  // Clock and reset
  input wire                   clk_i,
  input wire                   nrst_i,
  // Pins and register port
  input wire                   reset_pin_n_i,
  input wire                   low_power_request_pin_i,
  input wire                   rd_i,
  input wire [7:0]             rdata_o,
  // Status
  input wire [`MIPSM_ST_W-1:0] module_state_o,
  input wire                   high_power_o,
  input wire                   electronics_rst_o,
  input wire                   state_changed_o,
  input wire [2*NUM_LG-1:0]    lane_state_o
);
  wire st_rst  = module_state_o == `MIPSM_ST_RESET;
  wire st_init = module_state_o == `MIPSM_ST_MGMT_INIT;
  wire st_low  = module_state_o == `MIPSM_ST_LOW_PWR;
  wire st_up   = module_state_o == `MIPSM_ST_PWR_UP;
  wire st_rdy  = module_state_o == `MIPSM_ST_READY;
  wire st_dn   = module_state_o == `MIPSM_ST_PWR_DN;
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Window covers pin synchroniser and minimum pulse filter
  a_reset_from_pin: assert property (!reset_pin_n_i [*8] |-> ##[0:8] st_rst)
    else $error("reset pin ignored");
  // Lane update may trail the state by one cycle
  a_reset_quiet: assert property (st_rst ##1 st_rst |-> electronics_rst_o && !high_power_o && lane_state_o == '0)
    else $error("reset state not quiet");
  a_reset_exit: assert property (st_rst ##1 !st_rst |-> st_init)
    else $error("reset left to wrong state");
  a_init_quiet: assert property (st_init |-> !high_power_o && lane_state_o == '0)
    else $error("init state not quiet");
  a_init_exit: assert property (st_init ##1 !st_init |-> st_low || st_up || st_rst || module_state_o == `MIPSM_ST_FAULT)
    else $error("init left to wrong state");
  a_power_mode: assert property (!st_dn |-> high_power_o == (st_up || st_rdy))
    else $error("power mode wrong for state");
  a_lp_exit: assert property (not (((st_up || st_rdy) && low_power_request_pin_i) [*8]))
    else $error("low power request ignored");
  a_lp_hold: assert property ((st_low && low_power_request_pin_i) [*6] |=> !st_up)
    else $error("powered up under low power request");
  a_flag_ready: assert property (st_up ##1 st_rdy |-> ##[0:1] state_changed_o)
    else $error("state flag missing on ready");
  a_rd_refused: assert property (rd_i && (st_rst || st_init) |=> rdata_o == 8'h00)
    else $error("read served during init");
endmodule // mipsm_checker

bind mipsm_top mipsm_checker #(.NUM_LG(NUM_LG)) u_chk (.clk_i, .nrst_i, .reset_pin_n_i,
  .low_power_request_pin_i, .rd_i, .rdata_o, .module_state_o, .high_power_o,
  .electronics_rst_o, .state_changed_o, .lane_state_o);

/* File: sim/testbench.sv */
// Self-checking bench for the module state machine
`timescale 1ns/1ns
`include "mipsm_map.vh"
module testbench;
  logic        clk_i   = 1'b0;
  logic        nrst_i  = 1'b0;
  logic        lp_pin  = 1'b0;
  logic        hw_mode = 1'b0;
  logic        fault   = 1'b0;
  logic        rst_req = 1'b0;
  logic        supply  = 1'b1;
  logic        ce      = 1'b1;
  logic [3:0]  addr_i  = 4'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  wire         rpin_n;
  wire         pgood;
  wire         hp;
  wire         erst;
  wire  [7:0]  rdata_o;
  wire  [6:0]  st;
  wire  [3:0]  lanes;
  wire         mrdy;
  wire         tmo;
  wire         chg;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  // Register rows: address beside expected read data
  logic [11:0] rows [6] = '{12'h204, 12'h301, 12'h300, 12'h100, 12'h400, 12'hF00};

  // Pin held low long enough to engage the pulse assertion
  mipsm_host_model #(.RST_CYC(10)) host (.clk_i(clk_i), .rst_req_i(rst_req), .supply_on_i(supply),
    .reset_pin_n_o(rpin_n), .power_good_o(pgood));
  // Short lane init keeps the run brief
  mipsm_top #(.NUM_LG(2), .RST_MIN_NS(200), .INIT_MAX_CYC(20), .LG_INIT_CYC(8),
    .HW_PWRUP_DEFAULT(8'h03)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce),
    .reset_pin_n_i(rpin_n), .low_power_request_pin_i(lp_pin), .init_mode_hw_i(hw_mode),
    .power_good_i(pgood), .fault_i(fault), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .module_state_o(st), .high_power_o(hp),
    .electronics_rst_o(erst), .mgmt_ready_o(mrdy), .init_timeout_o(tmo), .state_changed_o(chg),
    .lane_state_o(lanes));

  initial forever #25 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, e, rdata_o);
  endtask
  // Bounded wait, then the state must match
  task automatic wait_st(input logic [6:0] s, input int lim);
    #1;
    for (int i = 0; i < lim && st !== s; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk("state", {1'b0, s}, {1'b0, st});
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic pin_reset();
    rst_req <= 1'b1;
    @(posedge clk_i);
    rst_req <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    #1 chk("reset hold", 8'h01, {7'h0, erst});
    nrst_i <= 1'b1;
    wait_st(`MIPSM_ST_MGMT_INIT, 12);
    wait_st(`MIPSM_ST_LOW_PWR, 20);
    for (int i = 0; i < 6; i++) begin
      rd(rows[i][11:8], rows[i][7:0], "reg row");
    end
    chk("port ready", 8'h01, {7'h0, mrdy});
    chk("no timeout", 8'h00, {7'h0, tmo});
    $display("init test done");
    lp_pin <= 1'b1;
    repeat (8) @(posedge clk_i);
    wr(`MIPSM_REG_PWRUP, 8'h01);
    repeat (20) @(posedge clk_i);
    #1 chk("lp hold", 8'h04, {1'b0, st});
    lp_pin <= 1'b0;
    wait_st(`MIPSM_ST_PWR_UP, 10);
    chk("high power", 8'h01, {7'h0, hp});
    wait_st(`MIPSM_ST_READY, 30);
    chk("lane active", 8'h02, {4'h0, lanes});
    rd(`MIPSM_REG_FLAGS, 8'h01, "flag");
    $display("power up test done");
    wr(`MIPSM_REG_PWRUP, 8'h00);
    repeat (30) @(posedge clk_i);
    #1 chk("stay ready", 8'h10, {1'b0, st});
    chk("lanes off", 8'h00, {4'h0, lanes});
    // Force while the lane is still initialising
    wr(`MIPSM_REG_PWRUP, 8'h01);
    wr(`MIPSM_REG_CTRL, 8'h01);
    wait_st(`MIPSM_ST_PWR_DN, 6);
    wait_st(`MIPSM_ST_LOW_PWR, 40);
    chk("lanes idle", 8'h00, {4'h0, lanes});
    wr(`MIPSM_REG_PWRUP, 8'h00);
    wr(`MIPSM_REG_CTRL, 8'h00);
    $display("power down test done");
    hw_mode <= 1'b1;
    repeat (10) @(posedge clk_i);
    #1 chk("mode ignored", 8'h04, {1'b0, st});
    wr(`MIPSM_REG_CTRL, 8'h02);
    wait_st(`MIPSM_ST_RESET, 3);
    wait_st(`MIPSM_ST_MGMT_INIT, 10);
    rd(`MIPSM_REG_STATE, 8'h00, "init read");
    chk("mgmt busy", 8'h00, {7'h0, mrdy});
    wait_st(`MIPSM_ST_PWR_UP, 20);
    wait_st(`MIPSM_ST_READY, 30);
    rd(`MIPSM_REG_PWRUP, 8'h03, "hw default");
    $display("hardware init test done");
    lp_pin <= 1'b1;
    pin_reset();
    wait_st(`MIPSM_ST_RESET, 12);
    wait_st(`MIPSM_ST_MGMT_INIT, 20);
    wait_st(`MIPSM_ST_LOW_PWR, 20);
    rd(`MIPSM_REG_FLAGS, 8'h01, "init flag");
    chk("flag cleared", 8'h00, {7'h0, chg});
    lp_pin <= 1'b0;
    $display("init override test done");
    fault <= 1'b1;
    wait_st(`MIPSM_ST_FAULT, 10);
    chk("fault power", 8'h00, {7'h0, hp});
    chk("fault flag", 8'h01, {7'h0, chg});
    fault  <= 1'b0;
    supply <= 1'b0;
    pin_reset();
    repeat (20) @(posedge clk_i);
    #1 chk("no supply", 8'h01, {1'b0, st});
    supply <= 1'b1;
    wait_st(`MIPSM_ST_MGMT_INIT, 12);
    $display("fault test done");
    // Low clock enable must stall the init counter
    ce <= 1'b0;
    repeat (20) @(posedge clk_i);
    #1 chk("frozen init", 8'h02, {1'b0, st});
    chk("frozen busy", 8'h00, {7'h0, mrdy});
    ce <= 1'b1;
    wait_st(`MIPSM_ST_PWR_UP, 20);
    chk("no init flag", 8'h00, {7'h0, chg});
    chk("init in time", 8'h00, {7'h0, tmo});
    chk("mgmt ready", 8'h01, {7'h0, mrdy});
    $display("clock enable test done");
    end_of_test();
  end
endmodule // testbench
